// file: hw/rtb_timebase.sv
// timebase counters, interval counter and interval compare of the time interval counter
`timescale 1ns/10ps
// Notes on behaviour
// R01: interval counter equal to compare value sets match flag, interrupt if enabled.
// R02: software loads an interval compare value between 0 and 255.
// R03: with time clock enabled, sub-second count steps every 1/128 second.
// R04: sub-second runs 0..127, wraps and bumps seconds in the same step.
// R05: non-power reset keeps time if time clock enabled, else clears to zero.
// R06: seconds advance once per second from the sub-second wrap.
// R07: seconds run 0..59, wrap and bump minutes.
// R08: minutes advance once per minute from the seconds wrap.
// R09: minutes run 0..59, wrap and bump hours.
// R10: hours run 0..23 then return to zero.
// R11: clearing time clock enable stops counting and clears prescaler and time.
// R12: time registers writable only while time clock enable is low.
// R13: two-bit select picks which step (sub-second tick, or sub-second, seconds or minutes wrap) advances the interval counter.
// R14: power-on reset clears interval compare and all time registers.
module rtb_timebase
	import rtb_pkg::*;
#(
	parameter int TICK_DIV = 256
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sys_rst_i,
	input  wire logic       xtal_tick_i,
	input  wire logic       sfr_wr_i,
	input  wire logic       sfr_rd_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       irq_enable_i,
	output logic      [7:0] sfr_rdata_o,
	output logic            sfr_hit_o,
	output logic            irq_o
);
	// ==========================================
	// state
	logic [7:0] ctl_q;
	logic [7:0] presc_q;
	logic [7:0] subsec_q;
	logic [7:0] secs_q;
	logic [7:0] min_q;
	logic [7:0] hour_q;
	logic [7:0] ival_q;
	logic [7:0] icnt_q;
	logic       clk_en;
	logic       en_fall;
	logic       tien;
	logic       tick128;
	logic       wrap_sub;
	logic       wrap_secs;
	logic       wrap_min;
	logic       ival_step;
	logic       match;
	logic       wr_time;
	rtb_timebase_t tb_sel;

	function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] last);
		wrap_inc = (v == last) ? 8'h00 : 8'(v + 8'h01);
	endfunction

	function automatic logic hit(input logic [7:0] a);
		hit = sfr_wr_i && (sfr_addr_i == a);
	endfunction

	assign clk_en  = ctl_q[RTB_CTL_CLKEN_BIT];
	assign tien    = ctl_q[RTB_CTL_TIEN_BIT];
	assign tb_sel  = rtb_timebase_t'(ctl_q[RTB_CTL_TBS_HI:RTB_CTL_TBS_LO]);
	// R03: sub-second tick from the prescaler
	assign tick128 = clk_en && xtal_tick_i && (presc_q == 8'(TICK_DIV - 1));
	// R04: sub-second wrap
	assign wrap_sub  = tick128 && (subsec_q == RTB_SUBSEC_LAST);
	// R07: seconds wrap
	assign wrap_secs = wrap_sub && (secs_q == RTB_SECONDS_LAST);
	// R09: minutes wrap
	assign wrap_min  = wrap_secs && (min_q == RTB_MINUTES_LAST);
	// R12: time writes only with clock off
	assign wr_time = !clk_en;
	// R11: enable cleared by a write
	assign en_fall = clk_en && !sys_rst_i && hit(RTB_ADDR_CONTROL)
		&& !sfr_wdata_i[RTB_CTL_CLKEN_BIT];

	// R13: timebase select
	always_comb begin
		case (tb_sel)
			RTB_TB_SUBSEC:  ival_step = tick128;
			RTB_TB_SECONDS: ival_step = wrap_sub;
			RTB_TB_MINUTES: ival_step = wrap_secs;
			RTB_TB_HOURS:   ival_step = wrap_min;
			default:        ival_step = 1'b0;
		endcase
	end

	// R01: compare on the interval step
	assign match = tien && ival_step && (8'(icnt_q + 8'h01) == ival_q);

	// ==========================================
	// control register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl_q <= RTB_CTL_RESET;
		end else if (sys_rst_i) begin
			// R05: enable survives if set
			ctl_q <= clk_en ? (RTB_CTL_RESET | 8'h01) : RTB_CTL_RESET;
		end else begin
			if (hit(RTB_ADDR_CONTROL)) begin
				ctl_q <= sfr_wdata_i;
			end
			// R01: set wins over software clear
			if (match) begin
				ctl_q[RTB_CTL_MATCH_BIT] <= 1'b1;
				if (ctl_q[RTB_CTL_STI_BIT]) begin
					ctl_q[RTB_CTL_TIEN_BIT] <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// prescaler and time registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			// R14: power-on clear
			presc_q  <= 8'h00;
			subsec_q <= RTB_TIME_RESET;
			secs_q   <= RTB_TIME_RESET;
			min_q    <= RTB_TIME_RESET;
			hour_q   <= RTB_TIME_RESET;
		end else if ((sys_rst_i && !clk_en) || en_fall) begin
			// R05: non-power reset clears only with clock off
			// R11: enable falling clears time
			presc_q  <= 8'h00;
			subsec_q <= RTB_TIME_RESET;
			secs_q   <= RTB_TIME_RESET;
			min_q    <= RTB_TIME_RESET;
			hour_q   <= RTB_TIME_RESET;
		end else if (!clk_en) begin
			// R11: clock off clears prescaler
			presc_q <= 8'h00;
			if (wr_time && hit(RTB_ADDR_SUBSEC)) begin
				subsec_q <= sfr_wdata_i;
			end
			if (wr_time && hit(RTB_ADDR_SECONDS)) begin
				secs_q <= sfr_wdata_i;
			end
			if (wr_time && hit(RTB_ADDR_MINUTES)) begin
				min_q <= sfr_wdata_i;
			end
			if (wr_time && hit(RTB_ADDR_HOURS)) begin
				hour_q <= sfr_wdata_i;
			end
		end else if (!sys_rst_i) begin
			if (xtal_tick_i) begin
				presc_q <= (presc_q == 8'(TICK_DIV - 1)) ? 8'h00 : 8'(presc_q + 8'h01);
			end
			// R03: sub-second step
			if (tick128) begin
				subsec_q <= wrap_inc(subsec_q, RTB_SUBSEC_LAST);
			end
			// R06: seconds step
			if (wrap_sub) begin
				secs_q <= wrap_inc(secs_q, RTB_SECONDS_LAST);
			end
			// R08: minutes step
			if (wrap_secs) begin
				min_q <= wrap_inc(min_q, RTB_MINUTES_LAST);
			end
			// R10: hours step
			if (wrap_min) begin
				hour_q <= wrap_inc(hour_q, RTB_HOURS_LAST);
			end
		end
	end

	// ==========================================
	// interval compare and interval counter
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			// R14: compare cleared at power-on
			ival_q <= RTB_INTERVAL_RESET;
		end else if (sys_rst_i) begin
			ival_q <= RTB_INTERVAL_RESET;
		end else if (hit(RTB_ADDR_INTERVAL)) begin
			ival_q <= sfr_wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			icnt_q <= 8'h00;
		end else if (sys_rst_i || !tien) begin
			icnt_q <= 8'h00;
		end else if (match) begin
			// R01: reload after match
			icnt_q <= 8'h00;
		end else if (ival_step) begin
			icnt_q <= 8'(icnt_q + 8'h01);
		end
	end

	// ==========================================
	// read port and interrupt
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_rd_i) begin
			case (sfr_addr_i)
				RTB_ADDR_CONTROL:  sfr_rdata_o <= ctl_q;
				RTB_ADDR_SUBSEC:   sfr_rdata_o <= subsec_q;
				RTB_ADDR_SECONDS:  sfr_rdata_o <= secs_q;
				RTB_ADDR_MINUTES:  sfr_rdata_o <= min_q;
				RTB_ADDR_HOURS:    sfr_rdata_o <= hour_q;
				RTB_ADDR_INTERVAL: sfr_rdata_o <= ival_q;
				default:           sfr_rdata_o <= 8'h00;
			endcase
		end
	end

	assign sfr_hit_o = (sfr_addr_i >= RTB_ADDR_CONTROL) && (sfr_addr_i <= RTB_ADDR_INTERVAL);
	// R01: interrupt gated by enable
	assign irq_o = ctl_q[RTB_CTL_MATCH_BIT] && irq_enable_i;
endmodule

// file: hw/rtb_pkg.sv
// package: register map, field layout, reset values and timing counts of the timebase block
package rtb_pkg;
	// ==========================================
	// register addresses in the special-function space
	localparam logic [7:0] RTB_ADDR_CONTROL  = 8'ha1;
	localparam logic [7:0] RTB_ADDR_SUBSEC   = 8'ha2;
	localparam logic [7:0] RTB_ADDR_SECONDS  = 8'ha3;
	localparam logic [7:0] RTB_ADDR_MINUTES  = 8'ha4;
	localparam logic [7:0] RTB_ADDR_HOURS    = 8'ha5;
	localparam logic [7:0] RTB_ADDR_INTERVAL = 8'ha6;
	// ==========================================
	// control register fields
	localparam int RTB_CTL_CLKEN_BIT = 0;
	localparam int RTB_CTL_TIEN_BIT  = 1;
	localparam int RTB_CTL_MATCH_BIT = 2;
	localparam int RTB_CTL_STI_BIT   = 3;
	localparam int RTB_CTL_TBS_LO    = 4;
	localparam int RTB_CTL_TBS_HI    = 5;
	localparam logic [7:0] RTB_CTL_RESET = 8'h00;
	// ==========================================
	// reset values and count limits
	localparam logic [7:0] RTB_TIME_RESET     = 8'h00;
	localparam logic [7:0] RTB_INTERVAL_RESET = 8'h00;
	localparam logic [7:0] RTB_SUBSEC_LAST    = 8'h7f;
	localparam logic [7:0] RTB_SECONDS_LAST   = 8'h3b;
	localparam logic [7:0] RTB_MINUTES_LAST   = 8'h3b;
	localparam logic [7:0] RTB_HOURS_LAST     = 8'h17;
	// ==========================================
	// timebase select encoding
	typedef enum logic [1:0] {
		RTB_TB_SUBSEC,
		RTB_TB_SECONDS,
		RTB_TB_MINUTES,
		RTB_TB_HOURS
	} rtb_timebase_t;
	// ==========================================
	// timing
	localparam int RTB_CLK_MHZ          = 250;
	localparam int RTB_CLEAR_HOLD_NS_X10 = 305;
	localparam int RTB_CLEAR_HOLD_CYCLES =
		(RTB_CLEAR_HOLD_NS_X10 * 100 * RTB_CLK_MHZ + 9999) / 10000;
endpackage

// file: dv/rtb_props.sv
// checker: port properties of the timebase block
`timescale 1ns/10ps
module rtb_props
	import rtb_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       sys_rst_i,
	input wire logic       xtal_tick_i,
	input wire logic       sfr_wr_i,
	input wire logic       sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic       irq_enable_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       sfr_hit_o,
	input wire logic       irq_o
);
	// ==========================================
	// enable shadow and read sequence
	logic en_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
		end else if (sfr_wr_i && sfr_addr_i == RTB_ADDR_CONTROL) begin
			en_q <= sfr_wdata_i[RTB_CTL_CLKEN_BIT];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rd(logic [7:0] a);
		sfr_rd_i && sfr_addr_i == a && !sys_rst_i;
	endsequence
	// ==========================================
	// properties
	AST_RST: assert property (disable iff (1'b0) rst_i |-> sfr_rdata_o == 8'h00 && !irq_o)
		else $error("outputs not clear in reset");
	AST_IRQ: assert property (!irq_enable_i |-> !irq_o)
		else $error("irq while masked");
	AST_SUB: assert property (s_rd(RTB_ADDR_SUBSEC) |=> sfr_rdata_o <= RTB_SUBSEC_LAST)
		else $error("subsec out of range");
	AST_SEC: assert property (s_rd(RTB_ADDR_SECONDS) |=> sfr_rdata_o <= RTB_SECONDS_LAST)
		else $error("seconds out of range");
	AST_MIN: assert property (s_rd(RTB_ADDR_MINUTES) |=> sfr_rdata_o <= RTB_MINUTES_LAST)
		else $error("minutes out of range");
	AST_HR: assert property (s_rd(RTB_ADDR_HOURS) |=> sfr_rdata_o <= RTB_HOURS_LAST)
		else $error("hours out of range");
	AST_IV: assert property (
		s_rd(RTB_ADDR_INTERVAL) ##0 $past(sfr_wr_i && sfr_addr_i == RTB_ADDR_INTERVAL && !sys_rst_i)
		|=> sfr_rdata_o == $past(sfr_wdata_i, 2)) else $error("compare readback wrong");
	AST_SYS: assert property (
		sys_rst_i && !en_q ##1 s_rd(RTB_ADDR_SECONDS) |=> sfr_rdata_o == RTB_TIME_RESET)
		else $error("time kept across reset while disabled");
endmodule
bind rtb_timebase rtb_props u_props (
	.clk_i       (clk_i),
	.rst_i       (rst_i),
	.sys_rst_i   (sys_rst_i),
	.xtal_tick_i (xtal_tick_i),
	.sfr_wr_i    (sfr_wr_i),
	.sfr_rd_i    (sfr_rd_i),
	.sfr_addr_i  (sfr_addr_i),
	.sfr_wdata_i (sfr_wdata_i),
	.irq_enable_i(irq_enable_i),
	.sfr_rdata_o (sfr_rdata_o),
	.sfr_hit_o   (sfr_hit_o),
	.irq_o       (irq_o)
);

// file: dv/tb.sv
// testbench: self-checking run of the timebase block
`timescale 1ns/10ps
module tb
	import rtb_pkg::*;
;
	logic       clk_i = 0, rst_i = 0, sys_rst_i = 0, xtal_tick_i = 0, rd_q = 0;
	logic       sfr_wr_i = 0, sfr_rd_i = 0, irq_enable_i = 1, sfr_hit_o, irq_o;
	logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o, exp_q[$];
	int         fails = 0, tests_run = 0, seed = 7380, n;
	rtb_timebase #(
		.TICK_DIV(2)
	) dut (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.sys_rst_i   (sys_rst_i),
		.xtal_tick_i (xtal_tick_i),
		.sfr_wr_i    (sfr_wr_i),
		.sfr_rd_i    (sfr_rd_i),
		.sfr_addr_i  (sfr_addr_i),
		.sfr_wdata_i (sfr_wdata_i),
		.irq_enable_i(irq_enable_i),
		.sfr_rdata_o (sfr_rdata_o),
		.sfr_hit_o   (sfr_hit_o),
		.irq_o       (irq_o)
	);
	initial forever #2 clk_i = ~clk_i;
	// ==========================================
	// tasks
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d, bit then_rd = 0);
		sfr_wr_i <= 1;
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		@(posedge clk_i);
		sfr_wr_i <= 0;
		if (then_rd) begin
			exp_q.push_back(d);
			sfr_rd_i <= 1;
			@(posedge clk_i);
			sfr_rd_i <= 0;
		end
		@(posedge clk_i);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		exp_q.push_back(e);
		sfr_rd_i <= 1;
		sfr_addr_i <= a;
		@(posedge clk_i);
		sfr_rd_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic tick(int k);
		repeat (k) begin
			xtal_tick_i <= 1;
			@(posedge clk_i);
			xtal_tick_i <= 0;
			@(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask
	task automatic sys_pulse();
		sys_rst_i <= 1;
		@(posedge clk_i);
		sys_rst_i <= 0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ==========================================
	// read monitor
	always @(posedge clk_i) begin
		if (rd_q && exp_q.size() > 0) chk("rdata", sfr_rdata_o, exp_q.pop_front());
		rd_q <= sfr_rd_i;
	end
	// ==========================================
	// main sequence
	initial begin
		rst_i <= 1;
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		for (int a = 'ha0; a <= 'ha7; a++) begin
			rd(8'(a), 8'h00);
			chk("hit", {7'h00, sfr_hit_o},
				{7'h00, (a inside {[RTB_ADDR_CONTROL:RTB_ADDR_INTERVAL]})});
		end
		repeat (4) wr(RTB_ADDR_INTERVAL, 8'($random(seed)), 1);
		wr(RTB_ADDR_SUBSEC, 8'h7f);
		wr(RTB_ADDR_SECONDS, 8'h3b);
		wr(RTB_ADDR_MINUTES, 8'h3b);
		wr(RTB_ADDR_HOURS, 8'h17, 1);
		wr(RTB_ADDR_CONTROL, 8'h01);
		wr(RTB_ADDR_SECONDS, 8'h11);
		tick(2);
		for (int a = 'ha2; a <= 'ha5; a++) rd(8'(a), 8'h00);
		tick(10);
		sys_pulse();
		rd(RTB_ADDR_SUBSEC, 8'h05);
		wr(RTB_ADDR_CONTROL, 8'h00);
		repeat (RTB_CLEAR_HOLD_CYCLES) @(posedge clk_i);
		rd(RTB_ADDR_SUBSEC, 8'h00);
		wr(RTB_ADDR_SECONDS, 8'h22);
		sys_pulse();
		rd(RTB_ADDR_SECONDS, 8'h00);
		wr(RTB_ADDR_INTERVAL, 8'h02);
		wr(RTB_ADDR_CONTROL, 8'h03);
		tick(4);
		n = 0;
		while (irq_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50) begin
			fails++;
			report_and_stop();
		end
		rd(RTB_ADDR_CONTROL, 8'h07);
		irq_enable_i <= 0;
		repeat (2) @(posedge clk_i);
		chk("irq", {7'h00, irq_o}, 8'h00);
		wr(RTB_ADDR_CONTROL, 8'h00);
		wr(RTB_ADDR_INTERVAL, 8'h01);
		wr(RTB_ADDR_CONTROL, 8'h13);
		tick(254);
		rd(RTB_ADDR_CONTROL, 8'h13);
		tick(2);
		rd(RTB_ADDR_SECONDS, 8'h01);
		rd(RTB_ADDR_CONTROL, 8'h17);
		wr(RTB_ADDR_CONTROL, 8'h00);
		wr(RTB_ADDR_SUBSEC, 8'h7f);
		wr(RTB_ADDR_SECONDS, 8'h3b);
		wr(RTB_ADDR_CONTROL, 8'h23);
		tick(2);
		rd(RTB_ADDR_MINUTES, 8'h01);
		rd(RTB_ADDR_CONTROL, 8'h27);
		wr(RTB_ADDR_CONTROL, 8'h00);
		wr(RTB_ADDR_SUBSEC, 8'h7f);
		wr(RTB_ADDR_SECONDS, 8'h3b);
		wr(RTB_ADDR_MINUTES, 8'h3b);
		wr(RTB_ADDR_CONTROL, 8'h3b);
		tick(2);
		rd(RTB_ADDR_HOURS, 8'h01);
		rd(RTB_ADDR_CONTROL, 8'h3d);
		report_and_stop();
	end
endmodule
